// *** design/switch_ctrl.sv ***
// Serial-bus slave and channel control of the two-channel bus switch
`timescale 1ns/1ps
module switch_ctrl
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_pin_lo,
  input wire logic addr_select_pin_hi,
  input wire logic downstream_irq_in_ch0,
  input wire logic downstream_irq_in_ch1,
  output logic irq_out,
  output logic irq_oe,
  output switch_ctrl_pkg::chan_pair_t chan_connect
);

  // Three-stage synchronisers; stage one is read only by stage two
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic [2:0] i0_sync_reg;
  logic [2:0] i1_sync_reg;
  logic [2:0] a0_sync_reg;
  logic [2:0] a1_sync_reg;
  logic scl_f_reg;
  logic sda_f_reg;
  logic i0_f_reg;
  logic i1_f_reg;
  logic a0_f_reg;
  logic a1_f_reg;
  logic scl_f_next;
  logic sda_f_next;
  logic i0_f_next;
  logic i1_f_next;
  logic a0_f_next;
  logic a1_f_next;

  always_comb
  begin
    scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
    sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
    i0_f_next = (i0_sync_reg[1] == i0_sync_reg[2]) ? i0_sync_reg[2] : i0_f_reg;
    i1_f_next = (i1_sync_reg[1] == i1_sync_reg[2]) ? i1_sync_reg[2] : i1_f_reg;
    a0_f_next = (a0_sync_reg[1] == a0_sync_reg[2]) ? a0_sync_reg[2] : a0_f_reg;
    a1_f_next = (a1_sync_reg[1] == a1_sync_reg[2]) ? a1_sync_reg[2] : a1_f_reg;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      i0_sync_reg <= 3'h7;
      i1_sync_reg <= 3'h7;
      a0_sync_reg <= 3'h0;
      a1_sync_reg <= 3'h0;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      i0_f_reg <= 1'b1;
      i1_f_reg <= 1'b1;
      a0_f_reg <= 1'b0;
      a1_f_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      i0_sync_reg <= {i0_sync_reg[1:0], downstream_irq_in_ch0};
      i1_sync_reg <= {i1_sync_reg[1:0], downstream_irq_in_ch1};
      a0_sync_reg <= {a0_sync_reg[1:0], addr_select_pin_lo};
      a1_sync_reg <= {a1_sync_reg[1:0], addr_select_pin_hi};
      scl_f_reg <= scl_f_next;
      sda_f_reg <= sda_f_next;
      i0_f_reg <= i0_f_next;
      i1_f_reg <= i1_f_next;
      a0_f_reg <= a0_f_next;
      a1_f_reg <= a1_f_next;
    end
  end

  // Bus protocol state
  logic scl_d_reg;
  logic sda_d_reg;
  switch_ctrl_pkg::bus_state_t state_reg;
  switch_ctrl_pkg::bus_state_t state_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] ctrl_reg;
  logic [3:0] ctrl_next;
  logic [1:0] active_reg;
  logic [1:0] active_next;
  logic drive_low_reg;
  logic drive_low_next;
  logic [4:0] hold_cnt_reg;
  logic [4:0] hold_cnt_next;
  logic pend_low_reg;
  logic pend_low_next;
  logic irq_reg;
  logic irq_next;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [7:0] read_byte;

  assign scl_rise = scl_f_reg && !scl_d_reg;
  assign scl_fall = !scl_f_reg && scl_d_reg;
  assign start_det = scl_f_reg && scl_d_reg && sda_d_reg && !sda_f_reg;
  assign stop_det = scl_f_reg && scl_d_reg && !sda_d_reg && sda_f_reg;

  // Upper nibble is status (bits 5:4 live interrupts, bits 7:6 zero); writes to it are discarded
  always_comb
  begin
    read_byte = 8'h00;
    read_byte[3:0] = ctrl_reg;
    read_byte[switch_ctrl_pkg::irq_ch0_bit] = i0_f_reg;
    read_byte[switch_ctrl_pkg::irq_ch1_bit] = i1_f_reg;
  end

  always_comb
  begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    ctrl_next = ctrl_reg;
    active_next = active_reg;
    drive_low_next = drive_low_reg;
    pend_low_next = pend_low_reg;
    hold_cnt_next = hold_cnt_reg;
    irq_next = !(i0_f_reg && i1_f_reg);
    // Except at start and stop, which release it at once, release or drive the data line only after the hold window following the fall
    if (hold_cnt_reg != 5'h00)
    begin
      hold_cnt_next = hold_cnt_reg - 5'h01;
      if (hold_cnt_reg == 5'h01)
        drive_low_next = pend_low_reg;
    end
    if (stop_det)
    begin
      state_next = switch_ctrl_pkg::st_idle;
      active_next = ctrl_reg[1:0];
      drive_low_next = 1'b0;
      hold_cnt_next = 5'h00;
    end
    else if (start_det)
    begin
      state_next = switch_ctrl_pkg::st_addr;
      bit_cnt_next = 4'h0;
      drive_low_next = 1'b0;
      hold_cnt_next = 5'h00;
    end
    else if (scl_rise)
    begin
      case (state_reg)
        switch_ctrl_pkg::st_addr, switch_ctrl_pkg::st_wr_data:
        begin
          shift_next = {shift_reg[6:0], sda_f_reg};
          bit_cnt_next = bit_cnt_reg + 4'h1;
        end
        switch_ctrl_pkg::st_rd_ack:
        begin
          // Master not acknowledging ends the read
          if (sda_f_reg)
            state_next = switch_ctrl_pkg::st_idle;
        end
        switch_ctrl_pkg::st_rd_data:
          bit_cnt_next = bit_cnt_reg + 4'h1;
        default:
          state_next = state_reg;
      endcase
    end
    else if (scl_fall)
    begin
      hold_cnt_next = 5'(switch_ctrl_pkg::data_hold_cycles);
      pend_low_next = 1'b0;
      case (state_reg)
        switch_ctrl_pkg::st_addr:
        begin
          if (bit_cnt_reg == 4'h8)
          begin
            if (shift_reg[7:3] == switch_ctrl_pkg::addr_prefix &&
                shift_reg[2] == a1_f_reg && shift_reg[1] == a0_f_reg)
            begin
              state_next = switch_ctrl_pkg::st_addr_ack;
              pend_low_next = 1'b1;
            end
            else
              state_next = switch_ctrl_pkg::st_idle;
          end
        end
        switch_ctrl_pkg::st_addr_ack:
        begin
          bit_cnt_next = 4'h0;
          if (shift_reg[0])
          begin
            state_next = switch_ctrl_pkg::st_rd_data;
            shift_next = read_byte;
            pend_low_next = !read_byte[7];
          end
          else
            state_next = switch_ctrl_pkg::st_wr_data;
        end
        switch_ctrl_pkg::st_wr_data:
        begin
          if (bit_cnt_reg == 4'h8)
          begin
            state_next = switch_ctrl_pkg::st_wr_ack;
            ctrl_next = shift_reg[3:0];
            pend_low_next = 1'b1;
          end
        end
        switch_ctrl_pkg::st_wr_ack:
        begin
          state_next = switch_ctrl_pkg::st_wr_data;
          bit_cnt_next = 4'h0;
        end
        switch_ctrl_pkg::st_rd_data:
        begin
          if (bit_cnt_reg == 4'h8)
            state_next = switch_ctrl_pkg::st_rd_ack;
          else
          begin
            shift_next = {shift_reg[6:0], 1'b0};
            pend_low_next = !shift_reg[6];
          end
        end
        switch_ctrl_pkg::st_rd_ack:
        begin
          state_next = switch_ctrl_pkg::st_rd_data;
          bit_cnt_next = 4'h0;
          shift_next = read_byte;
          pend_low_next = !read_byte[7];
        end
        default:
          state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= switch_ctrl_pkg::st_idle;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ctrl_reg <= switch_ctrl_pkg::ctrl_reset[3:0];
      active_reg <= switch_ctrl_pkg::ctrl_reset[1:0];
      drive_low_reg <= 1'b0;
      pend_low_reg <= 1'b0;
      hold_cnt_reg <= 5'h00;
      irq_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      scl_d_reg <= scl_f_reg;
      sda_d_reg <= sda_f_reg;
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      ctrl_reg <= ctrl_next;
      active_reg <= active_next;
      drive_low_reg <= drive_low_next;
      pend_low_reg <= pend_low_next;
      hold_cnt_reg <= hold_cnt_next;
      irq_reg <= irq_next;
    end
  end

  // Open drain: output data is always low, the enable pulls the line
  assign sda_out = 1'b0;
  assign sda_oe = drive_low_reg;
  assign irq_out = 1'b0;
  assign irq_oe = irq_reg;
  assign chan_connect.ch0 = active_reg[switch_ctrl_pkg::ch0_enable_bit];
  assign chan_connect.ch1 = active_reg[switch_ctrl_pkg::ch1_enable_bit];

endmodule

// *** inc/switch_ctrl_pkg.sv ***
// Constants and types for the two-channel bus switch control logic
package switch_ctrl_pkg;

  localparam logic [4:0] addr_prefix = 5'h0e;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam int ch0_enable_bit = 0;
  localparam int ch1_enable_bit = 1;
  localparam int irq_ch0_bit = 4;
  localparam int irq_ch1_bit = 5;
  localparam int status_zero_lo_bit = 6;
  localparam int status_zero_hi_bit = 7;
  localparam int clk_period_ns = 40;
  localparam int data_hold_ns = 300;
  localparam int data_hold_cycles = (data_hold_ns + clk_period_ns - 1) / clk_period_ns;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_addr = 3'b001,
    st_addr_ack = 3'b010,
    st_wr_data = 3'b011,
    st_wr_ack = 3'b100,
    st_rd_data = 3'b101,
    st_rd_ack = 3'b110
  } bus_state_t;

  typedef struct packed {
    logic ch1;
    logic ch0;
  } chan_pair_t;

endpackage

// *** testbench/i2c_master_model.sv ***
// Upstream bus master model for the bench
`timescale 1ns/1ps
module i2c_master_model
#(
  parameter int Q = 20
)
(
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Steps sit Q cycles apart, so clock low outlasts the device hold window
  task automatic t(input logic c, input logic d);
    repeat (Q) @(posedge ref_clk);
    #1 scl = c;
    sda_m = d;
  endtask
  task automatic start();
    t(1'b0, 1'b1);
    t(1'b1, 1'b1);
    t(1'b1, 1'b0);
    t(1'b0, 1'b0);
  endtask
  task automatic stop();
    t(1'b0, 1'b0);
    t(1'b1, 1'b0);
    t(1'b1, 1'b1);
  endtask
  // MSB first; a one releases the line to the pull-up
  task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    logic [8:0] s;
    logic [8:0] r;
    s = {d, a};
    for (int i = 8; i >= 0; i--)
    begin
      t(1'b0, s[i]);
      t(1'b1, s[i]);
      t(1'b1, s[i]);
      r[i] = sda;
      t(1'b0, s[i]);
    end
    q = r[8:1];
    k = r[0];
  endtask
endmodule

// *** testbench/switch_ctrl_chk.sv ***
// Assertion checker for the bus switch control logic
`timescale 1ns/1ps
module switch_ctrl_chk
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic downstream_irq_in_ch0,
  input wire logic downstream_irq_in_ch1,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire switch_ctrl_pkg::chan_pair_t chan_connect
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic sda_prev_reg;
  logic irq_all;
  assign irq_all = downstream_irq_in_ch0 & downstream_irq_in_ch1;
  // Cycles since a raw stop on the pins; saturates so it never wraps
  always_comb
  begin
    cnt_next = (cnt_reg == 4'hf) ? cnt_reg : cnt_reg + 4'h1;
    if (scl_in && sda_in && !sda_prev_reg)
      cnt_next = 4'h0;
    if (!rst_n)
      cnt_next = 4'hf;
  end
  always_ff @(posedge ref_clk)
  begin
    cnt_reg <= cnt_next;
    sda_prev_reg <= sda_in;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence irq_drop;
    $fell(irq_all);
  endsequence
  sequence scl_fall;
    $fell(scl_in);
  endsequence
  AST_CHAN_AT_STOP: assert property (!$stable(chan_connect) |-> cnt_reg <= 4'ha)
    else $error("channel change without stop");
  AST_IRQ_REACT: assert property (irq_drop |-> ##[1:8] irq_oe)
    else $error("irq output late");
  AST_IRQ_LOW: assert property ((!irq_all) [*8] |-> irq_oe)
    else $error("irq output not low");
  AST_IRQ_HIGH: assert property (irq_all [*8] |-> !irq_oe)
    else $error("irq output stuck");
  AST_HOLD_AFTER_FALL: assert property (scl_fall |=> $stable(sda_oe) [*8])
    else $error("data changed inside hold");
  AST_STEADY_IN_HIGH: assert property (scl_in [*6] |-> $stable(sda_oe))
    else $error("data changed in clock high");
  AST_OPEN_DRAIN: assert property (sda_out == 1'b0 && irq_out == 1'b0)
    else $error("open drain level wrong");
  AST_RESET_CLEARS: assert property (disable iff (1'b0)
    !rst_n |-> chan_connect == 2'b00 && !sda_oe && !irq_oe)
    else $error("reset did not clear");
endmodule
bind switch_ctrl switch_ctrl_chk chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq_out(irq_out), .irq_oe(irq_oe),
  .downstream_irq_in_ch0(downstream_irq_in_ch0), .chan_connect(chan_connect),
  .downstream_irq_in_ch1(downstream_irq_in_ch1));

// *** testbench/switch_ctrl_test.sv ***
// Self-checking bench of the bus switch control logic
`timescale 1ns/1ps
module switch_ctrl_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b1;
  logic ce = 1'b1;
  logic scl, sda_m, sda, sda_out, sda_oe, hi, lo, i0, i1, irq_out, irq_oe, k;
  switch_ctrl_pkg::chan_pair_t chan_connect;
  logic [7:0] q, d;
  logic [1:0] e;
  int n_errors = 0;
  int compares = 0;
  assign sda = sda_m & ~sda_oe;
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  i2c_master_model m (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  switch_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(ce), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_lo(lo),
    .addr_select_pin_hi(hi), .downstream_irq_in_ch0(i0), .downstream_irq_in_ch1(i1),
    .irq_out(irq_out), .irq_oe(irq_oe), .chan_connect(chan_connect));
  function automatic logic [7:0] ab(input logic rw);
    return {switch_ctrl_pkg::addr_prefix, hi, lo, rw};
  endfunction
  function automatic logic [7:0] rx(input logic [7:0] c);
    return {2'b00, i1, i0, c[3:0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd(input logic [7:0] c);
    m.start();
    m.xb(ab(1'b1), 1'b1, q, k);
    m.xb(8'hff, 1'b1, q, k);
    m.stop();
    chk(q, rx(c));
  endtask
  initial
  begin
    {hi, lo, i1, i0} = 4'h3;
    e = 2'b00;
    void'($urandom(32'h64feaee3));
    #5 rst_n = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    rd(8'h00);
    for (int n = 0; n < 8; n++)
    begin
      d = (n == 0) ? 8'hff : (n == 7) ? 8'h0f : 8'($urandom);
      {hi, lo, i1, i0} = 4'($urandom);
      m.start();
      m.xb(ab(1'b0), 1'b1, q, k);
      chk({7'h00, k}, 8'h00);
      m.xb(~d, 1'b1, q, k);
      m.xb(d, 1'b1, q, k);
      chk({7'h00, k}, 8'h00);
      chk({6'h00, chan_connect}, {6'h00, e});
      m.stop();
      repeat (8) @(posedge ref_clk);
      e = d[1:0];
      chk({6'h00, chan_connect}, {6'h00, e});
      chk({7'h00, irq_oe}, {7'h00, ~(i0 & i1)});
      rd(d);
      // Flip one address bit per pass, covering the pins and the prefix
      m.start();
      m.xb(ab(1'b0) ^ (8'h02 << (n % 7)), 1'b1, q, k);
      m.stop();
      chk({7'h00, k}, 8'h01);
      chk({6'h00, chan_connect}, {6'h00, e});
      $display("test %0d done", n);
    end
    // Enable held low: a whole write must leave no trace once it runs again
    ce = 1'b0;
    m.start();
    m.xb(ab(1'b0), 1'b1, q, k);
    m.xb({6'h00, ~e}, 1'b1, q, k);
    m.stop();
    chk({7'h00, k}, 8'h01);
    ce = 1'b1;
    repeat (8) @(posedge ref_clk);
    chk({6'h00, chan_connect}, {6'h00, e});
    $display("test freeze done");
    #1 rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({6'h00, chan_connect}, 8'h00);
    #1 rst_n = 1'b1;
    rd(8'h00);
    $display("test reset done");
    test_done();
  end
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    test_done();
  end
endmodule
